// >>> bb_pkg.sv
/*
  Shared constants and types of the block transfer engine: register map,
  control fields, function codes, engine states and the memory command.
  Assumes a 32-bit APB register bus and a 16-bit word memory port.
*/
// Notes on behaviour
// - Source and destination starts are pixel addresses; any bit of any word.
// - Source is shifted by the given count so first pixels line up.
// - Destination bits outside the rectangle keep their old values.
// - Only whole aligned words accessed; left mask first word, right mask last.
// - Edge masks stay fixed on every line during one operation.
// - Mask zero keeps the destination bit; mask one takes the result.
// - Bit zero of a 16-bit word is the first pixel, higher bits to the right.
// - Once per line, compute start addresses and test for completion; height lines.
// - Once per word read, combine, write, step; width words per line.
// - Software only sets up; the engine runs both loops by itself.
// - Horizontal either direction; vertical either direction for safe overlapped copies.
// - Increasing address by default; decreasing address reverses horizontal order.
// - Five instructions run internally; the external-unit transfer is not run here.
// - Vertical direction follows warp signs; horizontal follows the address option.
// - Increasing/decreasing and true/inverted source are exclusive pairs.
// - Function codes AND 1010, OR 0110, XOR 1110, fast OR 1100, store 0100.
package bb_pkg;

  localparam int APB_AW = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_SRC    = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DST    = 8'h04;
  localparam logic [APB_AW-1:0] OFS_SHIFT  = 8'h08;
  localparam logic [APB_AW-1:0] OFS_HEIGHT = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_MASK1  = 8'h10;
  localparam logic [APB_AW-1:0] OFS_MASK2  = 8'h14;
  localparam logic [APB_AW-1:0] OFS_SWARP  = 8'h18;
  localparam logic [APB_AW-1:0] OFS_DWARP  = 8'h1c;
  localparam logic [APB_AW-1:0] OFS_WIDTH  = 8'h20;
  localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h24;
  localparam logic [APB_AW-1:0] OFS_STAT   = 8'h28;

  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W   = 4;
  localparam int CTRL_DEC    = 4;
  localparam int CTRL_INV    = 5;
  localparam int CTRL_GO     = 8;

  // Status fields, write one to clear done and error
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR  = 2;

  // Function codes
  localparam logic [3:0] OP_AND  = 4'ha;
  localparam logic [3:0] OP_OR   = 4'h6;
  localparam logic [3:0] OP_XOR  = 4'he;
  localparam logic [3:0] OP_FOR  = 4'hc;
  localparam logic [3:0] OP_STORE = 4'h4;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam int          BYTES_PER_WORD_LOG2 = 1;
  localparam int          BITS_PER_BYTE_LOG2  = 3;

  typedef enum {ST_IDLE, ST_LINE, ST_RSRC, ST_RDST, ST_WR} state_t;

  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mem_cmd_t;

endpackage : bb_pkg

// >>> bb_src_align.sv
/*
  Source alignment funnel shifter: builds one destination-aligned word from
  the current and previously read source words. Pure combinational logic.
*/
`timescale 1ns/1ps
`default_nettype none
module bb_src_align #(
  parameter int W  = 16,
  parameter int SW = $clog2(W)
) (
  // Data in
  input  wire logic [W-1:0]  cur,
  input  wire logic [W-1:0]  prev,
  input  wire logic [SW-1:0] shift,
  input  wire logic          dec,
  // Aligned data
  output logic      [W-1:0]  aligned
);
  logic [2*W-1:0] up_pair;
  logic [2*W-1:0] dn_pair;

  // Increasing order moves pixels toward higher bit numbers
  assign up_pair = {cur, prev} << shift;
  // Decreasing order walks right to left, so the carry comes from above
  assign dn_pair = {prev, cur} >> shift;
  assign aligned = dec ? dn_pair[W-1:0] : up_pair[2*W-1:W];
endmodule : bb_src_align
`default_nettype wire

// >>> bb_rop.sv
/*
  Logical function unit with edge-mask merge for one destination word.
  Function codes come from the package; combinational only.
*/
`timescale 1ns/1ps
`default_nettype none
module bb_rop #(
  parameter int W = 16
) (
  // Function select
  input  wire logic [3:0]   op,
  input  wire logic         inv,
  // Operands
  input  wire logic [W-1:0] src,
  input  wire logic [W-1:0] dst,
  input  wire logic [W-1:0] mask,
  // Result
  output logic      [W-1:0] wdata
);
  logic [W-1:0] s;
  logic [W-1:0] res;

  assign s = inv ? ~src : src;

  always_comb begin
    unique case (op)
      bb_pkg::OP_AND:  res = s & dst;
      bb_pkg::OP_OR:   res = s | dst;
      bb_pkg::OP_XOR:  res = s ^ dst;
      bb_pkg::OP_FOR:  res = src | dst;
      bb_pkg::OP_STORE: res = s;
      default:         res = dst;
    endcase
  end

  // Zero mask bits protect neighbours
  assign wdata = (res & mask) | (dst & ~mask);
endmodule : bb_rop
`default_nettype wire

// >>> bb_engine.sv
/*
  Bit-aligned block transfer engine: APB register file plus the automatic
  per-line and per-word loops that read source and destination words,
  combine them and write the destination back.
  Assumes a word memory on the same clock answering each request with a
  one-cycle mem_ack while mem_req is held; read data valid with mem_ack.
*/
`timescale 1ns/1ps
`default_nettype none
module bb_engine #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 24,
  parameter int CNT_W  = 16
) (
  // Clock, reset, enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [bb_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Memory master
  output logic                       mem_req,
  output bb_pkg::mem_cmd_t           mem_cmd,
  input  wire logic [DATA_W-1:0]     mem_rdata,
  input  wire logic                  mem_ack,
  // Status
  output logic                       busy
);
  localparam int SW    = $clog2(DATA_W);
  localparam int PIX_W = ADDR_W + bb_pkg::BITS_PER_BYTE_LOG2;
  localparam logic [ADDR_W-1:0] STEP =
    ADDR_W'(1 << bb_pkg::BYTES_PER_WORD_LOG2);

  // Setup registers
  logic [PIX_W-1:0]  src_pix_reg;
  logic [PIX_W-1:0]  dst_pix_reg;
  logic [SW-1:0]     shift_reg;
  logic [CNT_W-1:0]  height_reg;
  logic [DATA_W-1:0] mask1_reg;
  logic [DATA_W-1:0] mask2_reg;
  logic [31:0]       swarp_reg;
  logic [31:0]       dwarp_reg;
  logic [CNT_W-1:0]  width_reg;
  logic [3:0]        op_reg;
  logic              dec_reg;
  logic              inv_reg;
  logic              done_reg;
  logic              err_reg;

  // Engine state
  bb_pkg::state_t    st_reg;
  logic [ADDR_W-1:0] lsrc_reg;
  logic [ADDR_W-1:0] ldst_reg;
  logic [ADDR_W-1:0] csrc_reg;
  logic [ADDR_W-1:0] cdst_reg;
  logic [CNT_W-1:0]  wleft_reg;
  logic [CNT_W-1:0]  hleft_reg;
  logic [DATA_W-1:0] prev_reg;
  logic [DATA_W-1:0] srcw_reg;
  logic              first_reg;
  logic              run_dec_reg;
  logic              run_inv_reg;

  // Bus decode and datapath nets
  logic              apb_acc;
  logic              apb_wr;
  logic              mapped;
  logic [31:0]       rd_next;
  logic              go_req;
  logic              op_legal;
  logic              start;
  logic              finish;
  logic [DATA_W-1:0] edge_mask;
  logic [DATA_W-1:0] aligned;
  logic [DATA_W-1:0] wr_word;
  logic [3:0]        wr_op;
  logic [2:0]        wr_dec_inv;

  assign apb_acc = psel && penable && pready;
  assign apb_wr  = apb_acc && pwrite && mapped;
  assign wr_op   = pwdata[bb_pkg::CTRL_OP_LSB +: bb_pkg::CTRL_OP_W];
  assign wr_dec_inv = {pwdata[bb_pkg::CTRL_GO], pwdata[bb_pkg::CTRL_INV],
                       pwdata[bb_pkg::CTRL_DEC]};
  assign go_req  = apb_wr && (paddr == bb_pkg::OFS_CTRL) && wr_dec_inv[2];

  // Only the five internal functions run; other codes are refused
  always_comb begin
    unique case (wr_op)
      bb_pkg::OP_AND, bb_pkg::OP_OR, bb_pkg::OP_XOR,
      bb_pkg::OP_FOR, bb_pkg::OP_STORE: op_legal = 1'b1;
      default:                         op_legal = 1'b0;
    endcase
  end
  assign start = go_req && op_legal && (st_reg == bb_pkg::ST_IDLE);

  always_comb begin
    mapped  = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (paddr)
      bb_pkg::OFS_SRC:    rd_next = 32'(src_pix_reg);
      bb_pkg::OFS_DST:    rd_next = 32'(dst_pix_reg);
      bb_pkg::OFS_SHIFT:  rd_next = 32'(shift_reg);
      bb_pkg::OFS_HEIGHT: rd_next = 32'(height_reg);
      bb_pkg::OFS_MASK1:  rd_next = 32'(mask1_reg);
      bb_pkg::OFS_MASK2:  rd_next = 32'(mask2_reg);
      bb_pkg::OFS_SWARP:  rd_next = swarp_reg;
      bb_pkg::OFS_DWARP:  rd_next = dwarp_reg;
      bb_pkg::OFS_WIDTH:  rd_next = 32'(width_reg);
      bb_pkg::OFS_CTRL:   rd_next = 32'({inv_reg, dec_reg, op_reg});
      bb_pkg::OFS_STAT:   rd_next = 32'({err_reg, done_reg, busy});
      default:            mapped  = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  // Setup writes are ignored while running, so masks cannot move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_pix_reg <= '0;
      dst_pix_reg <= '0;
      shift_reg   <= '0;
      height_reg  <= '0;
      mask1_reg   <= '0;
      mask2_reg   <= '0;
      swarp_reg   <= 32'h0000_0000;
      dwarp_reg   <= 32'h0000_0000;
      width_reg   <= '0;
      op_reg      <= bb_pkg::CTRL_RESET[3:0];
      dec_reg     <= 1'b0;
      inv_reg     <= 1'b0;
    end else if (ce && apb_wr && st_reg == bb_pkg::ST_IDLE) begin
      unique case (paddr)
        bb_pkg::OFS_SRC:    src_pix_reg <= pwdata[PIX_W-1:0];
        bb_pkg::OFS_DST:    dst_pix_reg <= pwdata[PIX_W-1:0];
        bb_pkg::OFS_SHIFT:  shift_reg   <= pwdata[SW-1:0];
        bb_pkg::OFS_HEIGHT: height_reg  <= pwdata[CNT_W-1:0];
        bb_pkg::OFS_MASK1:  mask1_reg   <= pwdata[DATA_W-1:0];
        bb_pkg::OFS_MASK2:  mask2_reg   <= pwdata[DATA_W-1:0];
        bb_pkg::OFS_SWARP:  swarp_reg   <= pwdata;
        bb_pkg::OFS_DWARP:  dwarp_reg   <= pwdata;
        bb_pkg::OFS_WIDTH:  width_reg   <= pwdata[CNT_W-1:0];
        bb_pkg::OFS_CTRL: begin
          op_reg  <= wr_op;
          // Each option pair is one bit, so both halves cannot be chosen
          dec_reg <= wr_dec_inv[0];
          inv_reg <= wr_dec_inv[1];
        end
        default: ;
      endcase
    end
  end

  // Sticky flags: a setting event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else if (ce) begin
      if (finish) begin
        done_reg <= 1'b1;
      end else if (apb_wr && paddr == bb_pkg::OFS_STAT && pwdata[bb_pkg::STAT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (go_req && !op_legal) begin
        err_reg <= 1'b1;
      end else if (apb_wr && paddr == bb_pkg::OFS_STAT && pwdata[bb_pkg::STAT_ERR]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // First and last word of each line take the edge masks
  always_comb begin
    edge_mask = {DATA_W{1'b1}};
    if (first_reg) begin
      edge_mask = edge_mask & mask1_reg;
    end
    if (wleft_reg == CNT_W'(1)) begin
      edge_mask = edge_mask & mask2_reg;
    end
  end

  bb_src_align #(
    .W  (DATA_W),
    .SW (SW)
  ) u_align (
    .cur     (mem_rdata),
    .prev    (prev_reg),
    .shift   (shift_reg),
    .dec     (run_dec_reg),
    .aligned (aligned)
  );

  bb_rop #(
    .W (DATA_W)
  ) u_rop (
    .op    (op_reg),
    .inv   (run_inv_reg),
    .src   (srcw_reg),
    .dst   (mem_rdata),
    .mask  (edge_mask),
    .wdata (wr_word)
  );

  assign finish = (st_reg == bb_pkg::ST_LINE) &&
                  (hleft_reg == '0 || width_reg == '0);

  // Nested line and word loops, no software between words or lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= bb_pkg::ST_IDLE;
      lsrc_reg    <= '0;
      ldst_reg    <= '0;
      csrc_reg    <= '0;
      cdst_reg    <= '0;
      wleft_reg   <= '0;
      hleft_reg   <= '0;
      prev_reg    <= '0;
      srcw_reg    <= '0;
      first_reg   <= 1'b0;
      run_dec_reg <= 1'b0;
      run_inv_reg <= 1'b0;
      mem_req     <= 1'b0;
      mem_cmd     <= '0;
      busy        <= 1'b0;
    end else if (ce) begin
      unique case (st_reg)
        bb_pkg::ST_IDLE: begin
          if (start) begin
            // Pixel address to aligned word byte address
            lsrc_reg  <= ADDR_W'({src_pix_reg[PIX_W-1:SW], 1'b0});
            ldst_reg  <= ADDR_W'({dst_pix_reg[PIX_W-1:SW], 1'b0});
            hleft_reg <= height_reg;
            // Fast OR always runs increasing with true source
            // Options taken from the go write, the option registers load on this edge
            run_dec_reg <= wr_dec_inv[0] && (wr_op != bb_pkg::OP_FOR);
            run_inv_reg <= wr_dec_inv[1] && (wr_op != bb_pkg::OP_FOR);
            busy      <= 1'b1;
            st_reg    <= bb_pkg::ST_LINE;
          end
        end
        bb_pkg::ST_LINE: begin
          if (finish) begin
            busy   <= 1'b0;
            st_reg <= bb_pkg::ST_IDLE;
          end else begin
            csrc_reg  <= lsrc_reg;
            cdst_reg  <= ldst_reg;
            wleft_reg <= width_reg;
            first_reg <= 1'b1;
            prev_reg  <= '0;
            mem_req   <= 1'b1;
            mem_cmd   <= '{we: 1'b0, addr: lsrc_reg, wdata: '0};
            st_reg    <= bb_pkg::ST_RSRC;
          end
        end
        bb_pkg::ST_RSRC: begin
          if (mem_ack) begin
            srcw_reg <= aligned;
            prev_reg <= mem_rdata;
            mem_cmd  <= '{we: 1'b0, addr: cdst_reg, wdata: '0};
            st_reg   <= bb_pkg::ST_RDST;
          end
        end
        bb_pkg::ST_RDST: begin
          if (mem_ack) begin
            mem_cmd <= '{we: 1'b1, addr: cdst_reg, wdata: wr_word};
            st_reg  <= bb_pkg::ST_WR;
          end
        end
        bb_pkg::ST_WR: begin
          if (mem_ack) begin
            // Address step direction from the option
            csrc_reg  <= run_dec_reg ? csrc_reg - STEP : csrc_reg + STEP;
            cdst_reg  <= run_dec_reg ? cdst_reg - STEP : cdst_reg + STEP;
            first_reg <= 1'b0;
            wleft_reg <= wleft_reg - CNT_W'(1);
            if (wleft_reg == CNT_W'(1)) begin
              // Signed warps pick up or down
              lsrc_reg  <= lsrc_reg + swarp_reg[ADDR_W-1:0];
              ldst_reg  <= ldst_reg + dwarp_reg[ADDR_W-1:0];
              hleft_reg <= hleft_reg - CNT_W'(1);
              mem_req   <= 1'b0;
              st_reg    <= bb_pkg::ST_LINE;
            end else begin
              mem_cmd <= '{we: 1'b0,
                           addr: run_dec_reg ? csrc_reg - STEP : csrc_reg + STEP,
                           wdata: '0};
              st_reg  <= bb_pkg::ST_RSRC;
            end
          end
        end
      endcase
    end
  end
endmodule : bb_engine
`default_nettype wire

// >>> bb_engine_sva.sv
/*
  Checker for the block transfer engine: APB answer timing and the memory
  command sequence. Sees only the engine's ports; bound at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module bb_engine_chk #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 24,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      ce,
  // APB
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [bb_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Memory
  input wire logic                      mem_req,
  input wire bb_pkg::mem_cmd_t          mem_cmd,
  input wire logic [DATA_W-1:0]         mem_rdata,
  input wire logic                      mem_ack,
  input wire logic                      busy
);
  logic [1:0] rd_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Reads acked since the last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cnt <= 2'h0;
    end else if (mem_req && mem_ack) begin
      rd_cnt <= mem_cmd.we ? 2'h0 : rd_cnt + 2'h1;
    end
  end

  ready_timing_a: assert property (psel && penable && !$past(penable) |-> ##1 pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr > bb_pkg::OFS_STAT
    || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  word_aligned_a: assert property (mem_req |-> !mem_cmd.addr[0])
    else $error("odd memory address");
  cmd_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("command changed before ack");
  two_reads_a: assert property (mem_req && mem_cmd.we |-> rd_cnt == 2'h2)
    else $error("write not after two reads");
  write_read_a: assert property (mem_req && mem_ack && mem_cmd.we |=> !mem_req || !mem_cmd.we)
    else $error("write after write");
  req_busy_a: assert property (mem_req |-> busy)
    else $error("request while idle");
  done_quiet_a: assert property ($fell(busy) |-> !mem_req)
    else $error("busy fell with request up");

  cover property (mem_req && mem_ack && mem_cmd.we);
  cover property (pready && pslverr);
  cover property ($fell(busy));
endmodule : bb_engine_chk
`default_nettype wire

bind bb_engine bb_engine_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .CNT_W(CNT_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack), .busy(busy));

// >>> mem_model.sv
/*
  Word memory behind the engine: 256 words, acks each command after lat+1
  idle cycles. The bench loads and inspects the array directly.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Request side
  input  wire logic             mem_req,
  input  wire bb_pkg::mem_cmd_t mem_cmd,
  input  wire logic [1:0]       lat,
  // Answer side
  output logic [15:0]           mem_rdata,
  output logic                  mem_ack
);
  logic [15:0] m [256];
  logic [15:0] last = 16'h0;
  logic [1:0]  cnt;
  logic [7:0]  idx;
  assign idx = mem_cmd.addr[8:1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt     <= 2'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      cnt     <= 2'h0;
    end else if (cnt == lat) begin
      mem_ack <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end

  // Bench also writes the array, so not always_ff
  always @(posedge pclk) begin
    if (mem_ack && mem_cmd.we) m[idx] <= mem_cmd.wdata;
    if (mem_ack) last <= mem_rdata;
  end

  // Outside an answer the bus shows no stale data
  assign mem_rdata = mem_ack ? m[idx] : ~last;
endmodule : mem_model
`default_nettype wire

// >>> bb_engine_tb.sv
/*
  Self-checking bench for the block transfer engine: APB tasks, a
  pixel-level reference of each blit, and memory compared word by word.
*/
`timescale 1ns/1ps
`default_nettype none
module bb_engine_tb;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             ce = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             mem_req;
  logic             mem_ack;
  logic             busy;
  logic [15:0]      mem_rdata;
  logic [1:0]       lat = 2'h0;
  bb_pkg::mem_cmd_t mem_cmd;
  logic [15:0]      expm [256];
  logic [31:0]      rv;
  logic             ev;
  logic [3:0]       ops [5] = '{bb_pkg::OP_AND, bb_pkg::OP_OR, bb_pkg::OP_XOR,
                                bb_pkg::OP_FOR, bb_pkg::OP_STORE};
  int               mismatches = 0;
  int               n_compared = 0;

  bb_engine dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .busy(busy));
  mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic load();
    for (int i = 0; i < 256; i++) begin
      mem_u.m[i] = 16'(i * 40503 + 4660);
      expm[i] = mem_u.m[i];
    end
  endtask : load

  // Blocks are 20 pixels, two words, wide; s and d are leftmost pixels
  task automatic blit(input logic [3:0] op, input logic inv, input logic dec, input int s,
                      input int d, input int sw, input int h, input logic [15:0] m1,
                      input logic [15:0] m2);
    int sp, dp, n;
    logic sb, db;
    for (int l = 0; l < h; l++) begin
      for (int x = 0; x < 20; x++) begin
        sp = s + l * sw * 8 + x;
        dp = d + l * sw * 8 + x;
        sb = expm[sp >> 4][sp % 16] ^ (inv && op != bb_pkg::OP_FOR);
        db = expm[dp >> 4][dp % 16];
        case (op)
          bb_pkg::OP_AND:  expm[dp >> 4][dp % 16] = sb & db;
          bb_pkg::OP_XOR:  expm[dp >> 4][dp % 16] = sb ^ db;
          bb_pkg::OP_STORE: expm[dp >> 4][dp % 16] = sb;
          default:         expm[dp >> 4][dp % 16] = sb | db;
        endcase
      end
    end
    apb(1'b1, bb_pkg::OFS_SRC, 32'(dec ? s + 19 : s));
    apb(1'b1, bb_pkg::OFS_DST, 32'(dec ? d + 19 : d));
    apb(1'b1, bb_pkg::OFS_SHIFT, 32'h3);
    apb(1'b1, bb_pkg::OFS_HEIGHT, 32'(h));
    apb(1'b1, bb_pkg::OFS_MASK1, {16'h0, m1});
    apb(1'b1, bb_pkg::OFS_MASK2, {16'h0, m2});
    apb(1'b1, bb_pkg::OFS_SWARP, 32'(sw));
    apb(1'b1, bb_pkg::OFS_DWARP, 32'(sw));
    apb(1'b1, bb_pkg::OFS_WIDTH, 32'h2);
    apb(1'b1, bb_pkg::OFS_CTRL, {23'h0, 1'b1, 2'h0, inv, dec, op});
    @(posedge pclk);
    check({31'h0, busy}, 32'h1);
    n = 0;
    do begin
      apb(1'b0, bb_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 200);
    check(rv, 32'h2);
    check({31'h0, busy}, 32'h0);
    apb(1'b1, bb_pkg::OFS_STAT, 32'h2);
    for (int i = 0; i < 256; i++) begin
      check({16'h0, mem_u.m[i]}, {16'h0, expm[i]});
    end
    $display("test blit op %h dec %0d done", op, dec);
  endtask : blit

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, bb_pkg::OFS_CTRL, 32'h0);
    check(rv, bb_pkg::CTRL_RESET);
    apb(1'b1, bb_pkg::OFS_MASK1, 32'h0000a5c3);
    apb(1'b0, bb_pkg::OFS_MASK1, 32'h0);
    check(rv, 32'h0000a5c3);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, ev}, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      lat <= 2'(i % 3);
      load();
      blit(ops[i], i == 2 || i == 3, 1'b0, 1, 2052, 8, 3, 16'hfff0, 16'h00ff);
    end
    load();
    blit(bb_pkg::OP_STORE, 1'b0, 1'b1, 4, 2049, 8, 3, 16'h001f, 16'hfffe);
    // Destination one line below source: only the upward order is safe
    load();
    blit(bb_pkg::OP_STORE, 1'b0, 1'b0, 385, 452, -8, 3, 16'hfff0, 16'h00ff);
    apb(1'b1, bb_pkg::OFS_CTRL, 32'h00000100);
    apb(1'b0, bb_pkg::OFS_STAT, 32'h0);
    check(rv, 32'h4);
    apb(1'b1, bb_pkg::OFS_STAT, 32'h4);
    apb(1'b0, bb_pkg::OFS_STAT, 32'h0);
    check(rv, 32'h0);
    $display("test bad function done");
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
endmodule : bb_engine_tb
`default_nettype wire
